//--- tcpg_pkg.sv
// Purpose: Shared constants for the timer set-up and waveform block
// Assumes: One peripheral clock at 50 MHz
// Notes:   Counter values are 16 bits wide
package tcpg_pkg;
    localparam int unsigned CNT_W      = 16;
    localparam int unsigned DIV_IDX_W  = 5;
    localparam int unsigned PRE_W      = 17;
    localparam logic [4:0]  DIV_IDX_MAX = 5'h10;
    localparam logic [15:0] CNT_ZERO   = 16'h0000;
    localparam logic [15:0] CNT_ONE    = 16'h0001;
    localparam logic [16:0] PRE_ZERO   = 17'h0_0000;
    localparam logic [16:0] PRE_ONE    = 17'h0_0001;

    typedef enum logic [1:0] {
        TCPG_MODE_TIMER,
        TCPG_MODE_PWM,
        TCPG_MODE_COUNTER
    } tcpg_mode_t;

    typedef enum logic [1:0] {
        TCPG_ST_IDLE,
        TCPG_ST_RUN,
        TCPG_ST_DONE
    } tcpg_state_t;
endpackage : tcpg_pkg

//--- tcpg_timer.sv
// Purpose: Timer 0 style unit with prescale, gating, counter mode, PWM pin
// Assumes: All inputs synchronous to i_ref_clk
// Notes:   Control bits are plain ports; no register bus
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Tick is clock divided by two power index
// - Rise enable raises interrupt on output rise
// - Period enable raises interrupt on output fall
// - Counter mode interrupts at target counts
// - Output enable drives waveform onto pin in timer and PWM modes
// - Output enable withholds timer pins from GPIO
// - Source select: outside pin or internal clock
// - Gating allowed only on internal clock
// - Invert setting flips gate level and clock
// - Prescaled clock advances counter, single or repeat
// - Gate input suspends counting unless disabled
// - Pulse inversion flips driven output
// - Count outside rising edges, or both
module tcpg_timer (
    // Clock and reset
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_rstn,
    // Set-up
    input  wire logic                  i_timer_enable,
    input  wire logic [4:0]            i_clock_divide_index,
    input  wire logic                  i_rising_edge_irq_en,
    input  wire logic                  i_period_end_irq_en,
    input  wire logic                  i_waveform_pin_drive_en,
    input  wire logic                  i_outside_clock_select,
    input  wire logic                  i_gate_polarity_and_clock_invert,
    input  wire logic                  i_pulse_output_invert,
    input  wire logic                  i_gating_input_off,
    input  wire logic                  i_count_both_edges,
    input  wire tcpg_pkg::tcpg_mode_t  i_mode,
    // Run control
    input  wire logic                  i_start,
    input  wire logic                  i_repeat,
    input  wire logic                  i_stop,
    input  wire logic [15:0]           i_hi_count,
    input  wire logic [15:0]           i_lo_count,
    input  wire logic                  i_irq_ack,
    // Pins
    input  wire logic                  i_outside_clock_pin,
    input  wire logic                  i_gate_pin,
    output logic                       o_pulse_out_pin,
    output logic                       o_pulse_out_oe,
    output logic                       o_gpio_withheld,
    // Status
    output logic                       o_rise_pending,
    output logic                       o_period_pending,
    output logic                       o_irq,
    output logic                       o_running
);
    tcpg_pkg::tcpg_state_t state_r;
    tcpg_pkg::tcpg_state_t state_nxt;
    logic [16:0]           pre_r;
    logic [16:0]           pre_nxt;
    logic [15:0]           cnt_r;
    logic [15:0]           cnt_nxt;
    logic                  wave_r;
    logic                  wave_nxt;
    logic                  rep_r;
    logic                  rep_nxt;
    logic                  ext_r;
    logic                  ext_nxt;
    logic                  rise_r;
    logic                  rise_nxt;
    logic                  per_r;
    logic                  per_nxt;
    logic                  pin_r;
    logic                  pin_nxt;
    logic                  oe_r;
    logic                  oe_nxt;
    logic                  gpio_r;
    logic                  gpio_nxt;
    logic                  irq_r;
    logic                  irq_nxt;
    logic                  run_r;
    logic                  run_nxt;
    logic [16:0] pre_lim;
    logic        tick, gated, ext_edge, adv, ev_rise, ev_per;
    logic [4:0]  idx;

    always_comb begin
        // Indexes above the top divide act as the top one
        idx     = (i_clock_divide_index > tcpg_pkg::DIV_IDX_MAX) ?
                  tcpg_pkg::DIV_IDX_MAX : i_clock_divide_index;
        pre_lim = (tcpg_pkg::PRE_ONE << idx) - tcpg_pkg::PRE_ONE;
        tick    = (pre_r == pre_lim);
        // Gate only on internal source; polarity from invert setting
        gated   = !i_outside_clock_select && !i_gating_input_off &&
                  (i_gate_pin == i_gate_polarity_and_clock_invert);
        // Clock invert picks falling edge of outside clock as active one
        ext_edge = (i_outside_clock_pin != ext_r) &&
                   (i_count_both_edges ||
                    (i_outside_clock_pin != i_gate_polarity_and_clock_invert));
        adv     = (state_r == tcpg_pkg::TCPG_ST_RUN) &&
                  (i_outside_clock_select ? ext_edge : (tick && !gated));
    end

    always_comb begin
        state_nxt = state_r;
        pre_nxt   = pre_r;
        cnt_nxt   = cnt_r;
        wave_nxt  = wave_r;
        rep_nxt   = rep_r;
        ev_rise   = 1'b0;
        ev_per    = 1'b0;
        ext_nxt   = i_outside_clock_pin;
        if (!gated || i_outside_clock_select)
            pre_nxt = tick ? tcpg_pkg::PRE_ZERO : pre_r + tcpg_pkg::PRE_ONE;
        case (state_r)
            tcpg_pkg::TCPG_ST_IDLE, tcpg_pkg::TCPG_ST_DONE: begin
                if (i_timer_enable && i_start) begin
                    state_nxt = tcpg_pkg::TCPG_ST_RUN;
                    cnt_nxt   = tcpg_pkg::CNT_ZERO;
                    pre_nxt   = tcpg_pkg::PRE_ZERO;
                    wave_nxt  = 1'b0;
                    rep_nxt   = i_repeat;
                end
            end
            tcpg_pkg::TCPG_ST_RUN: begin
                if (adv) begin
                    cnt_nxt = cnt_r + tcpg_pkg::CNT_ONE;
                    if (cnt_nxt == i_hi_count) begin
                        wave_nxt = 1'b1;
                        ev_rise  = 1'b1;
                    end
                    if (cnt_nxt == i_lo_count) begin
                        wave_nxt = 1'b0;
                        ev_per   = 1'b1;
                        cnt_nxt  = tcpg_pkg::CNT_ZERO;
                        if (!rep_r)
                            state_nxt = tcpg_pkg::TCPG_ST_DONE;
                    end
                end
            end
            default: state_nxt = tcpg_pkg::TCPG_ST_IDLE;
        endcase
        // Stop or disable drops the waveform at once
        if (i_stop || !i_timer_enable) begin
            state_nxt = tcpg_pkg::TCPG_ST_IDLE;
            wave_nxt  = 1'b0;
        end
    end

    // Set wins over acknowledge so no event is lost
    always_comb begin
        rise_nxt = (rise_r && !i_irq_ack) || (ev_rise && i_rising_edge_irq_en);
        per_nxt  = (per_r && !i_irq_ack) || (ev_per && i_period_end_irq_en);
        irq_nxt  = rise_nxt || per_nxt;
        run_nxt  = (state_nxt == tcpg_pkg::TCPG_ST_RUN);
    end

    // Pin in timer and PWM operation; counter mode keeps pin free
    always_comb begin
        oe_nxt   = i_timer_enable && i_waveform_pin_drive_en &&
                   (i_mode != tcpg_pkg::TCPG_MODE_COUNTER);
        gpio_nxt = i_timer_enable && i_waveform_pin_drive_en;
        pin_nxt  = oe_nxt && (wave_nxt ^ i_pulse_output_invert);
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            state_r <= tcpg_pkg::TCPG_ST_IDLE;
            pre_r   <= tcpg_pkg::PRE_ZERO;
            cnt_r   <= tcpg_pkg::CNT_ZERO;
            wave_r  <= 1'b0;
            rep_r   <= 1'b0;
            // Outside pin idles low, so no false edge after reset
            ext_r   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            pre_r   <= pre_nxt;
            cnt_r   <= cnt_nxt;
            wave_r  <= wave_nxt;
            rep_r   <= rep_nxt;
            ext_r   <= ext_nxt;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            rise_r  <= 1'b0;
            per_r   <= 1'b0;
            irq_r   <= 1'b0;
            run_r   <= 1'b0;
        end else begin
            rise_r  <= rise_nxt;
            per_r   <= per_nxt;
            irq_r   <= irq_nxt;
            run_r   <= run_nxt;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            pin_r   <= 1'b0;
            oe_r    <= 1'b0;
            gpio_r  <= 1'b0;
        end else begin
            pin_r   <= pin_nxt;
            oe_r    <= oe_nxt;
            gpio_r  <= gpio_nxt;
        end
    end

    assign o_pulse_out_pin  = pin_r;
    assign o_pulse_out_oe   = oe_r;
    assign o_gpio_withheld  = gpio_r;
    assign o_rise_pending   = rise_r;
    assign o_period_pending = per_r;
    assign o_irq            = irq_r;
    assign o_running        = run_r;
endmodule : tcpg_timer

`default_nettype wire

//--- tcpg_timer_sva.sv
// Purpose: Port checker for the timer unit
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to every timer instance
`timescale 1ns/1ps
`default_nettype none
module tcpg_timer_sva (
    input wire logic i_ref_clk, i_rstn, i_timer_enable, i_waveform_pin_drive_en,
    input wire logic i_rising_edge_irq_en, i_start, i_stop, i_irq_ack,
    input wire tcpg_pkg::tcpg_mode_t i_mode,
    input wire logic o_pulse_out_pin, o_pulse_out_oe, o_gpio_withheld,
    input wire logic o_rise_pending, o_period_pending, o_running
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);
    a_pin_needs_oe: assert property (!o_pulse_out_oe |-> !o_pulse_out_pin)
        else $error("pin high while not driven");
    a_no_drive_cnt: assert property (i_mode == tcpg_pkg::TCPG_MODE_COUNTER |=> !o_pulse_out_oe)
        else $error("pin driven in counter mode");
    a_gpio_withheld: assert property (i_timer_enable && i_waveform_pin_drive_en |=> o_gpio_withheld)
        else $error("pins not withheld");
    a_start_runs: assert property (i_start && i_timer_enable && !o_running && !i_stop |=> o_running)
        else $error("start not taken");
    a_stop_halts: assert property (i_stop |=> !o_running)
        else $error("stop ignored");
    a_rise_enabled: assert property ($rose(o_rise_pending) |-> $past(i_rising_edge_irq_en))
        else $error("rise pending while disabled");
    a_rise_holds: assert property (o_rise_pending && !i_irq_ack |=> o_rise_pending)
        else $error("rise pending lost");
    a_period_ack: assert property ($fell(o_period_pending) |-> $past(i_irq_ack))
        else $error("period pending cleared without ack");
endmodule : tcpg_timer_sva
bind tcpg_timer tcpg_timer_sva i_sva (.*);
`default_nettype wire

//--- tcpg_pin_model.sv
// Purpose: Outside clock and gate pins
// Assumes: Driven from the bench clock
// Notes: Clock stands low while not running
`timescale 1ns/1ps
`default_nettype none
module tcpg_pin_model (
    input  wire logic i_ref_clk,
    input  wire logic i_run,
    input  wire logic i_gate_lvl,
    output logic      o_outside_clock_pin,
    output logic      o_gate_pin
);
    logic [1:0] div_r = 2'h0;
    always @(posedge i_ref_clk) div_r <= i_run ? div_r + 2'h1 : 2'h0;
    assign o_outside_clock_pin = div_r[1];
    assign o_gate_pin = i_gate_lvl;
endmodule : tcpg_pin_model
`default_nettype wire

//--- tb_top.sv
// Purpose: Self-checking bench for the timer unit
// Assumes: 50 MHz clock, inputs moved at falling edge
// Notes: Random prescale and inversion, fixed seed
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 0, rstn = 0, en = 0, ri = 1, pi = 1, oe = 1, osel = 0, pol = 0, inv = 0;
    logic goff = 1, both = 0, st = 0, rep = 0, sp = 0, ack = 0, run_ck = 0, glvl = 1, pv;
    logic [4:0] idx = 5'h00;
    logic [15:0] hi = 16'h0001, lo = 16'h0002;
    tcpg_pkg::tcpg_mode_t md = tcpg_pkg::TCPG_MODE_PWM;
    wire logic ck, gt, pin, poe, wh, rp, pp, irq, runn;
    int err_total = 0, checks_done = 0, t0, dt;
    always #10 clk = ~clk;
    tcpg_pin_model i_pins (.i_ref_clk(clk), .i_run(run_ck), .i_gate_lvl(glvl),
        .o_outside_clock_pin(ck), .o_gate_pin(gt));
    tcpg_timer i_dut (.i_ref_clk(clk), .i_rstn(rstn), .i_timer_enable(en),
        .i_clock_divide_index(idx), .i_rising_edge_irq_en(ri), .i_period_end_irq_en(pi),
        .i_waveform_pin_drive_en(oe), .i_outside_clock_select(osel),
        .i_gate_polarity_and_clock_invert(pol), .i_pulse_output_invert(inv),
        .i_gating_input_off(goff), .i_count_both_edges(both), .i_mode(md), .i_start(st),
        .i_repeat(rep), .i_stop(sp), .i_hi_count(hi), .i_lo_count(lo), .i_irq_ack(ack),
        .i_outside_clock_pin(ck), .i_gate_pin(gt), .o_pulse_out_pin(pin),
        .o_pulse_out_oe(poe), .o_gpio_withheld(wh), .o_rise_pending(rp),
        .o_period_pending(pp), .o_irq(irq), .o_running(runn));
    task automatic chk(input logic ok, input string m);
        checks_done++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask : chk
    task automatic pulse(ref logic s);
        @(negedge clk) s = 1;
        @(negedge clk) s = 0;
    endtask : pulse
    // Time from rise event to period event, one advance apart
    task automatic go(input int lim);
        pulse(st);
        t0 = -1;
        dt = -1;
        for (int i = 0; i < lim; i++) begin
            @(negedge clk);
            if (rp === 1'b1 && t0 < 0) begin
                t0 = i;
                pv = pin;
            end
            if (pp === 1'b1 && dt < 0) dt = i - t0;
        end
    endtask : go
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop
    initial begin
        #200us;
        err_total++;
        report_and_stop();
    end
    initial begin
        void'($urandom(1337));
        repeat (5) @(negedge clk);
        rstn = 1;
        en = 1;
        for (int k = 0; k < 6; k++) begin
            @(negedge clk) idx = (k == 0) ? 5'h00 : 5'($urandom_range(0, 5));
            inv = 1'($urandom_range(0, 1));
            go(100);
            chk(dt == (1 << idx), "advance spacing");
            chk(pv === ~inv, "pin level at rise");
            chk(irq, "irq not raised");
            chk(runn === 1'b0, "single shot still running");
            pulse(ack);
            chk(!rp && !pp && !irq, "ack did not clear");
        end
        $display("prescale test done");
        @(negedge clk) {ri, pi, rep, idx} = 8'h20;
        go(20);
        chk(rp === 1'b0 && pp === 1'b0, "event while disabled");
        chk(runn === 1'b1, "repeat run stopped");
        pulse(sp);
        @(negedge clk) {ri, pi, oe, goff, rep, md} = {5'h18, tcpg_pkg::TCPG_MODE_TIMER};
        for (int p = 0; p < 2; p++) begin
            @(negedge clk) {pol, glvl} = {p[0], p[0]};
            go(40);
            chk(pp === 1'b0, "gate did not hold count");
            pulse(sp);
        end
        @(negedge clk) goff = 1;
        go(40);
        chk(pp, "gate-off ignored");
        pulse(ack);
        $display("gate test done");
        @(negedge clk) {md, osel, oe, pol, run_ck} = {tcpg_pkg::TCPG_MODE_COUNTER, 4'hD};
        {hi, lo, both} = {16'h0002, 16'h0003, 1'($urandom_range(0, 1))};
        go(100);
        chk(pp && poe === 1'b0, "counter targets");
        chk(wh === 1'b1, "pins not withheld");
        $display("counter test done");
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
